//--- rtl/ptmr_ahb.sv
`timescale 1ns/10ps
`default_nettype none
module ptmr_ahb
	import ptmr_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic hready_i,
	input wire logic [31:0] rd_data_i,
	output logic [7:0] rd_addr_o,
	output logic wr_en_o,
	output logic [7:0] wr_addr_o,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o
);
	// ******************************************************
	// Zero-wait slave; read data is sampled in the address phase
	// ******************************************************
	typedef struct packed {
		logic wr_pend;
		logic [7:0] addr;
		logic [31:0] rdata;
	} ptmr_ahb_s;
	ptmr_ahb_s st_reg;
	ptmr_ahb_s st_next;
	logic accept;
	always_comb begin
		st_next = st_reg;
		accept = hsel_i & htrans_i[1] & hready_i & (hsize_i == HSIZE_WORD);
		st_next.wr_pend = accept & hwrite_i;
		st_next.addr = haddr_i[7:0];
		if (accept & ~hwrite_i) begin
			st_next.rdata = rd_data_i;
		end
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign rd_addr_o = haddr_i[7:0];
	assign wr_en_o = st_reg.wr_pend;
	assign wr_addr_o = st_reg.addr;
	assign hrdata_o = st_reg.rdata;
	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;
endmodule
`default_nettype wire

//--- rtl/ptmr_pkg.sv
package ptmr_pkg;
	// ******************************************************
	// Register map and field layout
	// ******************************************************
	localparam logic [7:0] ADDR_CTRL0 = 8'h00;
	localparam logic [7:0] ADDR_CTRL1 = 8'h04;
	localparam logic [7:0] ADDR_COUNT = 8'h08;
	localparam logic [7:0] ADDR_CMPA = 8'h0C;
	localparam logic [7:0] ADDR_PERIOD = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam int RUN_BIT = 0;
	localparam int MODE_LO = 6;
	localparam int ACT_LO = 4;
	localparam int INIT_BIT = 3;
	localparam int INV_BIT = 2;
	localparam int CKS_BIT = 1;
	localparam int CCLR_BIT = 0;
	localparam int FLAG_A_BIT = 0;
	localparam int FLAG_P_BIT = 1;
	localparam int CNT_W = 10;
	// ******************************************************
	// Reset values and codes
	// ******************************************************
	localparam logic [9:0] VAL_RST = 10'h000;
	localparam logic [9:0] CNT_MAX = 10'h3FF;
	localparam logic [1:0] FIELD_RST = 2'h0;
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_CAP = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TC = 2'h3;
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_LOW = 2'h1;
	localparam logic [1:0] ACT_HIGH = 2'h2;
	localparam logic [1:0] ACT_TOGGLE = 2'h3;
	localparam logic [1:0] ACT_INACTIVE = 2'h0;
	localparam logic [1:0] ACT_ACTIVE = 2'h1;
	localparam logic [1:0] ACT_PWM = 2'h2;
	localparam logic [1:0] ACT_PULSE = 2'h3;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	typedef enum logic [2:0] {PM_CMP, PM_CAP, PM_PWM, PM_SP, PM_TC} ptmr_mode_e;
endpackage

//--- rtl/ptmr_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ptmr_sync
	import ptmr_pkg::*;
(
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic async_i,
	output logic rise_o
);
	// ******************************************************
	// Two-stage synchroniser with rising edge detect
	// ******************************************************
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} ptmr_sync_s;
	ptmr_sync_s st_reg;
	ptmr_sync_s st_next;
	always_comb begin
		st_next.s1 = async_i;
		st_next.s2 = st_reg.s1;
		st_next.s3 = st_reg.s2;
	end
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign rise_o = st_reg.s2 & ~st_reg.s3;
endmodule
`default_nettype wire

//--- rtl/ptmr_top.sv
`timescale 1ns/10ps
`default_nettype none
module ptmr_top
	import ptmr_pkg::*;
(
	input wire logic CORE_CLK_I,
	input wire logic RESET_I,
	input wire logic HSEL_I,
	input wire logic [31:0] HADDR_I,
	input wire logic [1:0] HTRANS_I,
	input wire logic HWRITE_I,
	input wire logic [2:0] HSIZE_I,
	input wire logic HREADY_I,
	input wire logic [31:0] HWDATA_I,
	output logic [31:0] HRDATA_O,
	output logic HREADYOUT_O,
	output logic HRESP_O,
	input wire logic EXT_TRIG_I,
	output logic TIMER_OUT_O,
	output logic TIMER_OUT_OE_O
);
	// ******************************************************
	// State
	// ******************************************************
	typedef struct packed {
		logic run;
		logic run_d;
		logic [1:0] mode;
		logic [1:0] act;
		logic init;
		logic inv;
		logic cks;
		logic cclr;
		logic [CNT_W-1:0] cmpa;
		logic [CNT_W-1:0] per;
		logic [CNT_W-1:0] cnt;
		logic flag_a;
		logic flag_p;
		logic pin;
		logic out;
		logic oe;
	} ptmr_state_s;
	ptmr_state_s st_reg;
	ptmr_state_s st_next;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic wr_en;
	logic [7:0] wr_addr;
	logic trig_rise;
	ptmr_mode_e md;
	logic run_rise;
	logic cnt_act;
	logic match_a;
	logic match_p;
	logic clr;
	logic duty;
	logic lvl;
	logic [CNT_W-1:0] per_last;
	// ******************************************************
	// Decode
	// ******************************************************
	function automatic ptmr_mode_e mode_of(input logic [1:0] m, input logic [1:0] a);
		ptmr_mode_e r;
		r = PM_CMP;
		unique case (m)
			MODE_CMP: r = PM_CMP;
			MODE_CAP: r = PM_CAP;
			MODE_PWM: r = (a == ACT_PULSE) ? PM_SP : PM_PWM;
			MODE_TC: r = PM_TC;
		endcase
		return r;
	endfunction
	function automatic logic [31:0] read_word(input logic [7:0] a, input ptmr_state_s s);
		logic [31:0] r;
		r = 32'h00000000;
		unique case (a)
			ADDR_CTRL0: r[RUN_BIT] = s.run;
			ADDR_CTRL1: r[7:0] = {s.mode, s.act, s.init, s.inv, s.cks, s.cclr};
			ADDR_COUNT: r[CNT_W-1:0] = s.cnt;
			ADDR_CMPA: r[CNT_W-1:0] = s.cmpa;
			ADDR_PERIOD: r[CNT_W-1:0] = s.per;
			ADDR_STATUS: r[1:0] = {s.flag_p, s.flag_a};
			default: r = 32'h00000000;
		endcase
		return r;
	endfunction
	// ******************************************************
	// Bus slave and trigger pin
	// ******************************************************
	ptmr_ahb u_ahb (
		.clk_i(CORE_CLK_I),
		.reset_i(RESET_I),
		.hsel_i(HSEL_I),
		.haddr_i(HADDR_I),
		.htrans_i(HTRANS_I),
		.hwrite_i(HWRITE_I),
		.hsize_i(HSIZE_I),
		.hready_i(HREADY_I),
		.rd_data_i(rd_data),
		.rd_addr_o(rd_addr),
		.wr_en_o(wr_en),
		.wr_addr_o(wr_addr),
		.hrdata_o(HRDATA_O),
		.hreadyout_o(HREADYOUT_O),
		.hresp_o(HRESP_O)
	);
	ptmr_sync u_trig (
		.clk_i(CORE_CLK_I),
		.reset_i(RESET_I),
		.async_i(EXT_TRIG_I),
		.rise_o(trig_rise)
	);
	assign rd_data = read_word(rd_addr, st_reg);
	// ******************************************************
	// Counter, comparators, flags and pin
	// ******************************************************
	always_comb begin
		st_next = st_reg;
		md = mode_of(st_reg.mode, st_reg.act);
		run_rise = st_reg.run & ~st_reg.run_d;
		cnt_act = st_reg.run & st_reg.run_d;
		per_last = st_reg.per - 10'h001;
		match_a = 1'b0;
		match_p = 1'b0;
		clr = 1'b0;
		duty = 1'b0;
		lvl = 1'b0;
		unique case (md)
			PM_CMP, PM_TC: begin
				match_a = cnt_act & (st_reg.cmpa != VAL_RST) & (st_reg.cnt == st_reg.cmpa);
				if (st_reg.cclr) begin
					clr = match_a;
				end else begin
					match_p = cnt_act & ((st_reg.per == VAL_RST) ? (st_reg.cnt == CNT_MAX) :
						(st_reg.cnt == st_reg.per));
					clr = match_p;
				end
			end
			PM_CAP: begin
				match_p = cnt_act & (st_reg.cnt == per_last);
				clr = match_p;
			end
			PM_PWM: begin
				match_p = cnt_act & (st_reg.cnt == per_last);
				match_a = cnt_act & (st_reg.cnt == st_reg.cmpa);
				clr = match_p;
			end
			PM_SP: begin
				match_a = cnt_act & (st_reg.cnt == st_reg.cmpa);
			end
		endcase
		// Counter is zeroed on the rising run edge and frozen while stopped.
		st_next.run_d = st_reg.run;
		if (run_rise) begin
			st_next.cnt = VAL_RST;
		end else if (cnt_act) begin
			st_next.cnt = clr ? VAL_RST : st_reg.cnt + 10'h001;
		end
		// Hardware set wins over a software clear in the same cycle.
		if (wr_en && wr_addr == ADDR_STATUS) begin
			st_next.flag_a = st_reg.flag_a & ~HWDATA_I[FLAG_A_BIT];
			st_next.flag_p = st_reg.flag_p & ~HWDATA_I[FLAG_P_BIT];
		end
		if (match_a) begin
			st_next.flag_a = 1'b1;
		end
		if (match_p) begin
			st_next.flag_p = 1'b1;
		end
		// A software write to the run bit overrides the automatic set and clear.
		if (md == PM_SP && match_a) begin
			st_next.run = 1'b0;
		end
		if (md == PM_SP && trig_rise && !st_reg.run) begin
			st_next.run = 1'b1;
		end
		if (wr_en) begin
			unique case (wr_addr)
				ADDR_CTRL0: st_next.run = HWDATA_I[RUN_BIT];
				ADDR_CTRL1: begin
					st_next.mode = HWDATA_I[MODE_LO+1:MODE_LO];
					st_next.act = HWDATA_I[ACT_LO+1:ACT_LO];
					st_next.init = HWDATA_I[INIT_BIT];
					st_next.inv = HWDATA_I[INV_BIT];
					st_next.cks = HWDATA_I[CKS_BIT];
					st_next.cclr = HWDATA_I[CCLR_BIT];
				end
				ADDR_CMPA: st_next.cmpa = HWDATA_I[CNT_W-1:0];
				ADDR_PERIOD: st_next.per = HWDATA_I[CNT_W-1:0];
				default: st_next.run = st_next.run;
			endcase
		end
		// Compare-mode pin state only moves on an A match or a run rise.
		if (md == PM_CMP && run_rise) begin
			st_next.pin = st_reg.init;
		end else if (md == PM_CMP && match_a) begin
			unique case (st_reg.act)
				ACT_NONE: st_next.pin = st_reg.pin;
				ACT_LOW: st_next.pin = 1'b0;
				ACT_HIGH: st_next.pin = 1'b1;
				ACT_TOGGLE: st_next.pin = ~st_reg.pin;
			endcase
		end
		duty = ((st_reg.per != VAL_RST) && (st_reg.cmpa >= st_reg.per)) ||
			(st_reg.cnt < st_reg.cmpa);
		unique case (md)
			PM_CMP: lvl = st_next.pin;
			PM_PWM: begin
				unique case (st_reg.act)
					ACT_INACTIVE: lvl = ~st_reg.init;
					ACT_ACTIVE: lvl = st_reg.init;
					default: lvl = duty ? st_reg.init : ~st_reg.init;
				endcase
			end
			PM_SP: lvl = st_next.run ? st_reg.init : ~st_reg.init;
			PM_CAP, PM_TC: lvl = 1'b0;
		endcase
		st_next.oe = (md != PM_TC) && (md != PM_CAP);
		st_next.out = st_next.oe & (lvl ^ st_reg.inv);
	end
	always_ff @(posedge CORE_CLK_I) begin
		if (RESET_I) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign TIMER_OUT_O = st_reg.out;
	assign TIMER_OUT_OE_O = st_reg.oe;
	// ******************************************************
	// Checks
	// ******************************************************
	// Half of the checks skip any cycle with a bus write, because a write may legally
	// retarget the mode, the run bit or the pin setup under them.
	default clocking cb @(posedge CORE_CLK_I);
	endclocking
	default disable iff (RESET_I);
	a_run_rise_zero: assert property (run_rise |=> st_reg.cnt == VAL_RST)
		else $error("counter not zeroed after run rise");
	// A stopped counter must keep its residual value for software to read.
	a_stop_holds: assert property (!st_reg.run ##1 !st_reg.run |-> $stable(st_reg.cnt))
		else $error("counter moved while stopped");
	a_cclr_a_clears: assert property (
		md == PM_CMP && st_reg.cclr && cnt_act && st_reg.cmpa != VAL_RST &&
		st_reg.cnt == st_reg.cmpa && !wr_en |=> st_reg.cnt == VAL_RST && st_reg.flag_a)
		else $error("compare A match did not clear counter");
	a_cclr_no_pflag: assert property (
		md == PM_CMP && st_reg.cclr && !st_reg.flag_p && !wr_en |=> !st_reg.flag_p)
		else $error("P flag raised with clear-source high");
	a_cmpa_zero_wrap: assert property (
		md == PM_CMP && st_reg.cclr && cnt_act && st_reg.cmpa == VAL_RST &&
		st_reg.cnt == CNT_MAX && !st_reg.flag_a && !wr_en
		|=> st_reg.cnt == VAL_RST && !st_reg.flag_a)
		else $error("compare A zero overflow wrong");
	a_flag_a_cmp: assert property (
		(md == PM_CMP || md == PM_TC) && cnt_act && st_reg.cmpa != VAL_RST &&
		st_reg.cnt == st_reg.cmpa |=> st_reg.flag_a)
		else $error("A flag missing on compare match");
	a_flag_p_cmp: assert property (
		md == PM_CMP && !st_reg.cclr && cnt_act && st_reg.per != VAL_RST &&
		st_reg.cnt == st_reg.per |=> st_reg.flag_p && st_reg.cnt == VAL_RST)
		else $error("P match did not clear counter and raise flag");
	a_pin_init: assert property (
		md == PM_CMP && run_rise && !wr_en |=> TIMER_OUT_O == (st_reg.init ^ st_reg.inv))
		else $error("pin not at initial level after run rise");
	a_p_no_pin: assert property (
		md == PM_CMP && match_p && !match_a && !run_rise |=> $stable(st_reg.pin))
		else $error("P match moved the pin");
	// The pin register may only move on an A match or a run rise, whatever else happens.
	a_pin_steady: assert property (
		md == PM_CMP && !match_a && !run_rise |=> $stable(st_reg.pin))
		else $error("pin moved without an A match");
	// A zero period reads back as 1023 here, which is exactly the 1024-clock wrap.
	a_pwm_period: assert property (
		md == PM_PWM && cnt_act && st_reg.cnt == 10'(st_reg.per - 10'h001)
		|=> st_reg.cnt == VAL_RST)
		else $error("PWM period wrong");
	a_pwm_count: assert property (
		md == PM_PWM && cnt_act && st_reg.cnt != 10'(st_reg.per - 10'h001)
		|=> st_reg.cnt == $past(st_reg.cnt) + 10'h001)
		else $error("PWM counter did not step");
	a_pwm_flags: assert property (
		md == PM_PWM && cnt_act && st_reg.cnt == st_reg.cmpa |=> st_reg.flag_a)
		else $error("PWM A flag missing");
	a_pwm_full: assert property (
		md == PM_PWM && st_reg.act == ACT_PWM && cnt_act && st_reg.per != VAL_RST &&
		st_reg.cmpa >= st_reg.per && !wr_en |=> TIMER_OUT_O == (st_reg.init ^ st_reg.inv))
		else $error("PWM not fully active");
	a_pwm_forced: assert property (
		md == PM_PWM && st_reg.act == ACT_INACTIVE && !wr_en
		|=> TIMER_OUT_O == (~st_reg.init ^ st_reg.inv))
		else $error("PWM forced inactive level wrong");
	a_pulse_end: assert property (
		md == PM_SP && match_a && !wr_en
		|=> !st_reg.run && TIMER_OUT_O == (~st_reg.init ^ st_reg.inv))
		else $error("single pulse did not end on A match");
	// The pin follows the run bit on the same edge, so the pulse width is exact.
	a_pulse_level: assert property (
		md == PM_SP && !wr_en
		|=> TIMER_OUT_O == ((st_reg.run ? st_reg.init : ~st_reg.init) ^ st_reg.inv))
		else $error("single pulse level wrong");
	a_pulse_count: assert property (
		md == PM_SP && cnt_act |=> st_reg.cnt == $past(st_reg.cnt) + 10'h001)
		else $error("single pulse counter cleared while running");
	a_trig_start: assert property (
		md == PM_SP && trig_rise && !st_reg.run && !wr_en
		|=> st_reg.run ##1 st_reg.cnt == VAL_RST)
		else $error("trigger did not start pulse");
	a_tc_undriven: assert property (md == PM_TC && !wr_en |=> !TIMER_OUT_OE_O)
		else $error("pin driven in timer mode");
	// ******************************************************
	// Coverage
	// ******************************************************
	c_cmp_toggle: cover property (md == PM_CMP && match_a && st_reg.act == ACT_TOGGLE);
	c_pwm_wrap: cover property (md == PM_PWM && match_p ##[1:8] match_a);
	c_pulse_done: cover property (md == PM_SP && run_rise ##[1:40] match_a);
	c_ext_start: cover property (md == PM_SP && trig_rise && !st_reg.run);
endmodule
`default_nettype wire

//--- testbench/ptmr_tb.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import ptmr_pkg::*;
	logic CORE_CLK_I = 1'b0;
	logic RESET_I = 1'b1;
	logic HSEL_I = 1'b0;
	logic [31:0] HADDR_I = 32'h00000000;
	logic [1:0] HTRANS_I = 2'h0;
	logic HWRITE_I = 1'b0;
	logic [2:0] HSIZE_I = HSIZE_WORD;
	logic [31:0] HWDATA_I = 32'h00000000;
	logic EXT_TRIG_I = 1'b0;
	wire logic HREADY_I;
	wire logic [31:0] HRDATA_O;
	wire logic HREADYOUT_O;
	wire logic HRESP_O;
	wire logic TIMER_OUT_O;
	wire logic TIMER_OUT_OE_O;
	logic [31:0] rdv;
	logic [31:0] keep;
	int miscompares = 0;
	int check_count = 0;
	// A single slave, so its ready is the bus ready.
	assign HREADY_I = HREADYOUT_O;
	ptmr_top uut (.CORE_CLK_I(CORE_CLK_I), .RESET_I(RESET_I), .HSEL_I(HSEL_I),
		.HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(HSIZE_I),
		.HREADY_I(HREADY_I), .HWDATA_I(HWDATA_I), .HRDATA_O(HRDATA_O),
		.HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O), .EXT_TRIG_I(EXT_TRIG_I),
		.TIMER_OUT_O(TIMER_OUT_O), .TIMER_OUT_OE_O(TIMER_OUT_OE_O));
	always #2.5 CORE_CLK_I = ~CORE_CLK_I;
	// ******************************************************
	// Bus and checking helpers
	// ******************************************************
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// The master waits on ready without a count; the watchdog cuts a hang.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge CORE_CLK_I);
		HSEL_I <= 1'b1;
		HADDR_I <= {24'h000000, a};
		HTRANS_I <= 2'h2;
		HWRITE_I <= w;
		do @(posedge CORE_CLK_I); while (HREADYOUT_O !== 1'b1);
		HTRANS_I <= 2'h0;
		HWDATA_I <= wd;
		do @(posedge CORE_CLK_I); while (HREADYOUT_O !== 1'b1);
		rdv = HRDATA_O;
		HSEL_I <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h00000000);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge CORE_CLK_I);
	endtask
	// Mode and action change only with the counter stopped.
	task automatic cfg(input logic [1:0] m, input logic [1:0] act, input logic ini,
		input logic inv, input logic cclr, input logic [9:0] ca, input logic [9:0] per);
		wr(ADDR_CTRL0, 32'h00000000);
		wr(ADDR_CTRL1, {24'h000000, m, act, ini, inv, 1'b0, cclr});
		wr(ADDR_CMPA, {22'h000000, ca});
		wr(ADDR_PERIOD, {22'h000000, per});
		wr(ADDR_STATUS, 32'h00000003);
	endtask
	// ******************************************************
	// Scenarios
	// ******************************************************
	task automatic t_reset();
		chk("oe", TIMER_OUT_OE_O, 32'h1);
		chk("hresp", HRESP_O, 32'h0);
		chk("hready", HREADYOUT_O, 32'h1);
		for (int i = 0; i < 7; i++) begin
			rd(8'(i * 4));
			chk("rst_reg", rdv, 32'h0);
		end
		wr(ADDR_CTRL1, 32'hFFFFFFFF);
		rd(ADDR_CTRL1);
		chk("ctrl1", rdv, 32'h000000FF);
		wr(ADDR_PERIOD, 32'hFFFFFFFF);
		rd(ADDR_PERIOD);
		chk("period", rdv, 32'h000003FF);
		$display("test reset done");
	endtask
	task automatic cmp_case(input logic [1:0] act, input logic ini, input logic inv,
		input logic exp);
		cfg(MODE_CMP, act, ini, inv, 1'b0, 10'h010, 10'h100);
		wr(ADDR_CTRL0, 32'h00000001);
		cyc(3);
		chk("pin_init", TIMER_OUT_O, ini ^ inv);
		cyc(30);
		chk("pin_match", TIMER_OUT_O, exp);
		rd(ADDR_STATUS);
		chk("flag_a_only", rdv, 32'h1);
	endtask
	task automatic t_cmp();
		cmp_case(ACT_NONE, 1'b1, 1'b0, 1'b1);
		cmp_case(ACT_LOW, 1'b1, 1'b0, 1'b0);
		cmp_case(ACT_HIGH, 1'b0, 1'b1, 1'b0);
		cmp_case(ACT_TOGGLE, 1'b0, 1'b0, 1'b1);
		$display("test compare done");
	endtask
	task automatic flag_case(input logic [1:0] m, input logic cclr, input logic [9:0] ca,
		input logic [9:0] per, input int n, input logic [31:0] exp);
		cfg(m, ACT_NONE, 1'b0, 1'b0, cclr, ca, per);
		wr(ADDR_CTRL0, 32'h00000001);
		cyc(n);
		rd(ADDR_STATUS);
		chk("flags", rdv, exp);
	endtask
	task automatic t_flags();
		flag_case(MODE_CMP, 1'b1, 10'h020, 10'h008, 100, 32'h1);
		flag_case(MODE_CMP, 1'b0, 10'h010, 10'h018, 100, 32'h3);
		flag_case(MODE_CMP, 1'b0, 10'h010, 10'h000, 1100, 32'h3);
		flag_case(MODE_TC, 1'b0, 10'h010, 10'h018, 100, 32'h3);
		chk("tc_oe", TIMER_OUT_OE_O, 32'h0);
		flag_case(MODE_CAP, 1'b0, 10'h010, 10'h018, 100, 32'h2);
		chk("cap_oe", TIMER_OUT_OE_O, 32'h0);
		flag_case(MODE_CMP, 1'b1, 10'h000, 10'h000, 1100, 32'h0);
		wr(ADDR_CTRL0, 32'h00000000);
		rd(ADDR_COUNT);
		keep = rdv;
		cyc(10);
		rd(ADDR_COUNT);
		chk("hold", rdv, keep);
		chk("wrapped", (keep > 32'h0) && (keep < 32'h100), 32'h1);
		wr(ADDR_CTRL0, 32'h00000001);
		rd(ADDR_COUNT);
		chk("restart", rdv < 32'h8, 32'h1);
		$display("test flags done");
	endtask
	task automatic pwm_case(input logic [1:0] act, input logic inv, input logic [9:0] ca,
		input int exp, input logic [31:0] fl);
		int hi;
		hi = 0;
		cfg(MODE_PWM, act, 1'b1, inv, 1'b1, ca, 10'h008);
		wr(ADDR_CTRL0, 32'h00000001);
		cyc(20);
		for (int i = 0; i < 80; i++) begin
			@(posedge CORE_CLK_I);
			hi += (TIMER_OUT_O === 1'b1) ? 1 : 0;
		end
		chk("pwm_high", 32'(hi), 32'(exp));
		rd(ADDR_STATUS);
		chk("pwm_flags", rdv, fl);
	endtask
	task automatic t_pwm();
		pwm_case(ACT_PWM, 1'b0, 10'h003, 30, 32'h3);
		pwm_case(ACT_PWM, 1'b1, 10'h003, 50, 32'h3);
		pwm_case(ACT_PWM, 1'b0, 10'h008, 80, 32'h2);
		pwm_case(ACT_PWM, 1'b0, 10'h00C, 80, 32'h2);
		pwm_case(ACT_INACTIVE, 1'b0, 10'h003, 0, 32'h3);
		pwm_case(ACT_ACTIVE, 1'b0, 10'h003, 80, 32'h3);
		$display("test pwm done");
	endtask
	task automatic t_pulse();
		cfg(MODE_PWM, ACT_PULSE, 1'b1, 1'b1, 1'b0, 10'h020, 10'h004);
		cyc(2);
		chk("sp_idle", TIMER_OUT_O, 32'h1);
		wr(ADDR_CTRL0, 32'h00000001);
		cyc(3);
		chk("sp_lead", TIMER_OUT_O, 32'h0);
		cyc(60);
		chk("sp_trail", TIMER_OUT_O, 32'h1);
		rd(ADDR_CTRL0);
		chk("sp_run", rdv, 32'h0);
		rd(ADDR_STATUS);
		chk("sp_flag", rdv & 32'h1, 32'h1);
		rd(ADDR_COUNT);
		keep = rdv;
		cyc(10);
		rd(ADDR_COUNT);
		chk("sp_hold", rdv, keep);
		EXT_TRIG_I <= 1'b1;
		cyc(8);
		chk("trig_lead", TIMER_OUT_O, 32'h0);
		rd(ADDR_CTRL0);
		chk("trig_run", rdv, 32'h1);
		cyc(60);
		chk("trig_trail", TIMER_OUT_O, 32'h1);
		EXT_TRIG_I <= 1'b0;
		cfg(MODE_CMP, ACT_NONE, 1'b0, 1'b0, 1'b0, 10'h020, 10'h000);
		EXT_TRIG_I <= 1'b1;
		cyc(8);
		rd(ADDR_CTRL0);
		chk("trig_cmp", rdv, 32'h0);
		EXT_TRIG_I <= 1'b0;
		$display("test pulse done");
	endtask
	// ******************************************************
	// Run control
	// ******************************************************
	task automatic summarize();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge CORE_CLK_I);
		RESET_I <= 1'b0;
		cyc(2);
		t_reset();
		t_cmp();
		t_flags();
		t_pwm();
		t_pulse();
		summarize();
	end
	// The tests need about 4000 cycles; this is generous head room.
	initial begin
		repeat (30000) @(posedge CORE_CLK_I);
		miscompares++;
		summarize();
	end
endmodule
`default_nettype wire
